// ---- verilog/gio_defines.svh ----
// constants for the general-purpose port block
// assumes inclusion by bare name from files under verilog/ and bench/
`ifndef GIO_DEFINES_SVH
`define GIO_DEFINES_SVH

// register byte offsets on the axi4-lite slave
`define GIO_OFS_INPUT     8'h00
`define GIO_OFS_DIRECTION 8'h04
`define GIO_OFS_OUTPUT    8'h08
`define GIO_OFS_MCUCTRL   8'h0C
`define GIO_OFS_SLEEP     8'h10
`define GIO_OFS_EXTINT    8'h14
`define GIO_OFS_EXTFLAG   8'h18

// field positions and reset values
`define GIO_PUD_BIT       4
`define GIO_MCUCTRL_RW    8'h1F
`define GIO_RST_DIRECTION 8'h00
`define GIO_RST_OUTPUT    8'h00
`define GIO_RST_MCUCTRL   8'h00

// axi responses
`define GIO_RESP_OKAY     2'h0
`define GIO_RESP_SLVERR   2'h2

`endif

// ---- verilog/gio_pkg.sv ----
// types shared by the general-purpose port block
// assumes no surroundings beyond the files under verilog/
package gio_pkg;

  typedef struct packed {
    logic [7:0] out_value;
    logic [7:0] out_enable;
    logic [7:0] pullup_enable;
  } gio_pad_ctrl_type;

  typedef enum logic [2:0] {
    GIO_WR_IDLE = 3'b001,
    GIO_WR_RESP = 3'b010,
    GIO_WR_HOLD = 3'b100
  } gio_wr_state_type;

endpackage

// ---- verilog/gio_pin_sync.sv ----
// input path of one port: sleep clamp, half-cycle latch, sample flop
// assumes pins are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none

module gio_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_level,
  input  wire logic [WIDTH-1:0] clamp_enable,
  output logic      [WIDTH-1:0] sample,
  output logic      [WIDTH-1:0] clamped_level
);

  logic [WIDTH-1:0] sync_latch;

  // clamp forces the digital input to ground before the trigger
  always_comb
  begin
    clamped_level = pin_level & ~clamp_enable;
  end

  // transparent while aclk is high, holds from the falling edge
  // non-blocking so the flop below still takes the held value at the edge
  always_latch
  begin
    if (aclk)
    begin
      sync_latch <= clamped_level;
    end
  end

  // second stage: taken at the next rising edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample <= '0;
    end
    else
    begin
      sample <= sync_latch;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/gio_port.sv ----
// eight-pin general-purpose port with axi4-lite register access
// assumes one 20 mhz clock; pads resolve out/oe/pullup outside
`timescale 1ns/1ps
`default_nettype none
`include "gio_defines.svh"

module gio_port #(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             sleep_request,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_pullup
);

  if (WIDTH != 8)
  begin : g_width_check
    $error("gio_port serves eight-pin ports only");
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [WIDTH-1:0] port_direction_reg;
  logic [WIDTH-1:0] port_output_reg;
  logic [7:0]       mcu_control_reg;
  logic [WIDTH-1:0] extint_enable;
  logic [WIDTH-1:0] extint_edge_sense;
  logic [WIDTH-1:0] extint_flag;
  logic [WIDTH-1:0] port_input_reg;
  logic [WIDTH-1:0] clamped_level;
  logic [WIDTH-1:0] clamped_prev;
  logic [1:0]       sleep_sync;
  logic             sleep_prev;
  logic             global_pullup_disable;
  gio_pkg::gio_pad_ctrl_type next_pad;

  assign global_pullup_disable = mcu_control_reg[`GIO_PUD_BIT];

  // -------------------------------------------------------------------
  // write channel
  // -------------------------------------------------------------------
  gio_pkg::gio_wr_state_type wr_state;
  logic [7:0]  aw_addr;
  logic        aw_have;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_have;
  logic        wr_fire;

  function automatic logic gio_mapped(input logic [7:0] addr);
    gio_mapped = (addr == `GIO_OFS_INPUT)     ||
                 (addr == `GIO_OFS_DIRECTION) ||
                 (addr == `GIO_OFS_OUTPUT)    ||
                 (addr == `GIO_OFS_MCUCTRL)   ||
                 (addr == `GIO_OFS_SLEEP)     ||
                 (addr == `GIO_OFS_EXTINT)    ||
                 (addr == `GIO_OFS_EXTFLAG);
  endfunction

  assign wr_fire = (wr_state == gio_pkg::GIO_WR_IDLE) && aw_have && w_have;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) &&
                       (wr_state == gio_pkg::GIO_WR_IDLE);
      s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready) &&
                       (wr_state == gio_pkg::GIO_WR_IDLE);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      else if (wr_fire)
      begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state     <= gio_pkg::GIO_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GIO_RESP_OKAY;
    end
    else
    begin
      unique case (wr_state)
        gio_pkg::GIO_WR_IDLE:
        begin
          if (wr_fire)
          begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= gio_mapped(aw_addr) ? `GIO_RESP_OKAY
                                                : `GIO_RESP_SLVERR;
            wr_state     <= gio_pkg::GIO_WR_RESP;
          end
        end
        gio_pkg::GIO_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state     <= gio_pkg::GIO_WR_HOLD;
          end
        end
        gio_pkg::GIO_WR_HOLD:
        begin
          // one spare cycle lets the ready flops recover cleanly
          wr_state <= gio_pkg::GIO_WR_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // port registers
  // -------------------------------------------------------------------
  logic wr_lane0;
  assign wr_lane0 = wr_fire && w_strb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_direction_reg <= `GIO_RST_DIRECTION;
    end
    else if (wr_lane0 && aw_addr == `GIO_OFS_DIRECTION)
    begin
      port_direction_reg <= w_data[WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_output_reg <= `GIO_RST_OUTPUT;
    end
    else if (wr_lane0 && aw_addr == `GIO_OFS_OUTPUT)
    begin
      port_output_reg <= w_data[WIDTH-1:0];
    end
    else if (wr_lane0 && aw_addr == `GIO_OFS_INPUT)
    begin
      // toggle regardless of direction; zero bits leave the output alone
      port_output_reg <= port_output_reg ^ w_data[WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mcu_control_reg   <= `GIO_RST_MCUCTRL;
      extint_enable     <= '0;
      extint_edge_sense <= '0;
    end
    else if (wr_lane0)
    begin
      if (aw_addr == `GIO_OFS_MCUCTRL)
      begin
        mcu_control_reg <= w_data[7:0] & `GIO_MCUCTRL_RW;
      end
      if (aw_addr == `GIO_OFS_EXTINT)
      begin
        extint_enable <= w_data[WIDTH-1:0];
      end
      if (aw_addr == `GIO_OFS_SLEEP)
      begin
        extint_edge_sense <= w_data[WIDTH-1:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // input path and sleep clamp
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_sync <= 2'h0;
    end
    else
    begin
      sleep_sync <= {sleep_sync[0], sleep_request};
    end
  end

  logic [WIDTH-1:0] clamp_enable;
  // enabled interrupt pins escape the clamp, disabled ones keep it
  assign clamp_enable = {WIDTH{sleep_sync[1]}} & ~extint_enable;

  // the latch stage is the pin's first synchroniser stage
  gio_pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .pin_level     (pin_in),
    .clamp_enable  (clamp_enable),
    .sample        (port_input_reg),
    .clamped_level (clamped_level)
  );

  // -------------------------------------------------------------------
  // interrupt flags: wake-up for clamped edge-sensing pins, toggles on enabled edge-sensing pins
  // -------------------------------------------------------------------
  // released level reaches the sample flop one cycle after the clamp opens
  logic wake_pulse;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_prev   <= 1'b0;
      wake_pulse   <= 1'b0;
      clamped_prev <= '0;
      extint_flag  <= '0;
    end
    else
    begin
      sleep_prev   <= sleep_sync[1];
      wake_pulse   <= sleep_prev && !sleep_sync[1];
      clamped_prev <= port_input_reg;
      // release of the clamp reads as a rising edge on a high pin
      extint_flag  <= (extint_flag &
                       ~((wr_lane0 && aw_addr == `GIO_OFS_EXTFLAG)
                         ? w_data[WIDTH-1:0] : '0)) |
                      (wake_pulse
                        ? (port_input_reg & extint_edge_sense &
                           ~extint_enable) : '0) |
                      (extint_enable & extint_edge_sense &
                       (port_input_reg ^ clamped_prev));
    end
  end

  // -------------------------------------------------------------------
  // pad control
  // -------------------------------------------------------------------
  always_comb
  begin
    next_pad.out_enable    = port_direction_reg;
    next_pad.out_value     = port_output_reg & port_direction_reg;
    // pull-up only for input with output bit set
    next_pad.pullup_enable = ~port_direction_reg & port_output_reg &
                             {WIDTH{!global_pullup_disable}};
  end

  // reset clears the pad flops asynchronously so pins float at once
  always_ff @(posedge aclk or negedge aresetn)
  begin
    if (!aresetn)
    begin
      pin_oe     <= '0;
      pin_out    <= '0;
      pin_pullup <= '0;
    end
    else
    begin
      pin_oe     <= next_pad.out_enable;
      pin_out    <= next_pad.out_value;
      pin_pullup <= next_pad.pullup_enable;
    end
  end

  // -------------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `GIO_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= gio_mapped({s_axi_araddr[7:2], 2'h0})
                        ? `GIO_RESP_OKAY : `GIO_RESP_SLVERR;
        unique case ({s_axi_araddr[7:2], 2'h0})
          `GIO_OFS_INPUT:     s_axi_rdata <= {24'h000000, port_input_reg};
          `GIO_OFS_DIRECTION: s_axi_rdata <= {24'h000000, port_direction_reg};
          `GIO_OFS_OUTPUT:    s_axi_rdata <= {24'h000000, port_output_reg};
          `GIO_OFS_MCUCTRL:   s_axi_rdata <= {24'h000000, mcu_control_reg};
          `GIO_OFS_SLEEP:     s_axi_rdata <= {24'h000000, extint_edge_sense};
          `GIO_OFS_EXTINT:    s_axi_rdata <= {24'h000000, extint_enable};
          `GIO_OFS_EXTFLAG:   s_axi_rdata <= {24'h000000, extint_flag};
          default:            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- bench/gio_port_monitor.sv ----
// concurrent checks on the pad and bus ports of gio_port
// assumes one clock domain, reset low and synchronous for the bus
`timescale 1ns/1ps
`default_nettype none

module gio_port_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pin_pullup
);
  default clocking mcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence pads_idle;
    pin_oe == 8'h00 && pin_pullup == 8'h00 && pin_out == 8'h00;
  endsequence

  a_pullup_not_driven: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_tristate: assert property (disable iff (1'b0)
    !aresetn |-> pads_idle) else $error("pads active in reset");
  a_release_idle: assert property ($rose(aresetn) |-> pads_idle [*2])
    else $error("pads active after reset");
  a_undriven_low: assert property ((pin_out & ~pin_oe) == 8'h00)
    else $error("drive value on undriven pin");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_resp_blocks: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_rdata_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
endmodule

bind gio_port gio_port_monitor mon (.*);

`default_nettype wire

// ---- bench/gio_board.sv ----
// board model: pads, external drivers, floating lines
// assumes the bench sets which lines are driven from outside
`timescale 1ns/1ps
`default_nettype none

module gio_board (
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_level
);
  logic [7:0] drift = 8'h00;

  // a floating line wanders, so nothing may rely on it
  always @(posedge aclk)
    drift <= ~drift;

  assign pin_level = (pin_out & pin_oe)
                   | (ext_level & ext_en & ~pin_oe)
                   | (pin_pullup & ~pin_oe & ~ext_en)
                   | (drift & ~pin_oe & ~ext_en & ~pin_pullup);
endmodule

`default_nettype wire

// ---- bench/gio_port_tb.sv ----
// self-checking bench for gio_port over axi4-lite
// assumes gio_board on the pads and the monitor bound in
`timescale 1ns/1ps
`default_nettype none
`include "gio_defines.svh"

module gio_port_tb;
  logic        aclk, aresetn, sleep_request;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_en, ext_level;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          errors, checked;

  gio_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_request,
    .pin_in, .pin_out, .pin_oe, .pin_pullup);

  gio_board board (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_en,
    .ext_level, .pin_level(pin_in));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (n == 50)
    begin
      errors++;
      give_verdict();
    end
    else
      chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (n == 50)
    begin
      errors++;
      give_verdict();
    end
    else
    begin
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask

  // pads move one edge after the register; two edges leave margin
  task automatic pads(input logic [23:0] e);
    repeat (2) @(posedge aclk);
    chk({8'h00, pin_oe, pin_out, pin_pullup}, {8'h00, e});
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    errors = 0;
    checked = 0;
    // scheduled so the pad flops see a falling edge at time zero
    aresetn <= 1'b0;
    sleep_request = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    ext_en = 8'hF0;
    ext_level = 8'h90;
    repeat (16) @(posedge aclk);
    pads(24'h000000);
    aresetn <= 1'b1;
    pads(24'h000000);
    axi_rd(`GIO_OFS_DIRECTION, 32'h0, `GIO_RESP_OKAY);
    axi_rd(`GIO_OFS_OUTPUT, 32'h0, `GIO_RESP_OKAY);
    axi_rd(`GIO_OFS_MCUCTRL, 32'h0, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_OUTPUT, 32'hA5, `GIO_RESP_OKAY);
    pads(24'h0000A5);
    axi_wr(`GIO_OFS_DIRECTION, 32'h0F, `GIO_RESP_OKAY);
    pads(24'h0F05A0);
    axi_wr(`GIO_OFS_MCUCTRL, 32'hFF, `GIO_RESP_OKAY);
    pads(24'h0F0500);
    axi_rd(`GIO_OFS_MCUCTRL, 32'h1F, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_MCUCTRL, 32'h00, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_INPUT, 32'h81, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_INPUT, 32'h00, `GIO_RESP_OKAY);
    axi_rd(`GIO_OFS_OUTPUT, 32'h24, `GIO_RESP_OKAY);
    pads(24'h0F0420);
    repeat (2) @(posedge aclk);
    axi_rd(`GIO_OFS_INPUT, 32'h94, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_SLEEP, 32'h10, `GIO_RESP_OKAY);
    sleep_request <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(`GIO_OFS_INPUT, 32'h00, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_EXTINT, 32'h80, `GIO_RESP_OKAY);
    repeat (4) @(posedge aclk);
    axi_rd(`GIO_OFS_INPUT, 32'h80, `GIO_RESP_OKAY);
    sleep_request <= 1'b0;
    repeat (8) @(posedge aclk);
    axi_rd(`GIO_OFS_EXTFLAG, 32'h10, `GIO_RESP_OKAY);
    axi_wr(`GIO_OFS_EXTFLAG, 32'h10, `GIO_RESP_OKAY);
    axi_rd(`GIO_OFS_EXTFLAG, 32'h00, `GIO_RESP_OKAY);
    axi_rd(8'h40, 32'h0, `GIO_RESP_SLVERR);
    axi_wr(8'h40, 32'h1, `GIO_RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    // a clocked reset would still show the pads here
    #1 chk({8'h00, pin_oe, pin_out, pin_pullup}, 32'h0);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`GIO_OFS_DIRECTION, 32'h0, `GIO_RESP_OKAY);
    give_verdict();
  end
endmodule

`default_nettype wire
